// [pbm_board_model.sv]
// file: model of the board circuitry on the three low port B pins
module pbm_board_model (
	input  wire logic [2:0] pinOut,
	input  wire logic [2:0] pinOe,
	input  wire logic [2:0] boardLevel,
	output logic      [2:0] pinIn
);
	timeunit 1ns;
	timeprecision 1ns;
	// a driven pin reads back its own level; a released pin follows the board
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			pinIn[i] = pinOe[i] ? pinOut[i] : boardLevel[i];
	end
endmodule : pbm_board_model

// [pbm_claim_decode.sv]
// module: combinational decode of timer channel claims on the three pins
module pbm_claim_decode (
	input  wire logic                              combinedMode,
	input  wire logic                              ch4PwmSelect,
	input  wire logic                              ch3PwmSelect,
	input  wire logic                              ch4AOutputEnable,
	input  wire logic                              ch3BOutputEnable,
	input  wire logic                              ch3AOutputEnable,
	input  wire logic [pbm_pkg::IO_FIELD_W-1:0]    ch4AIoCtrl,
	input  wire logic [pbm_pkg::IO_FIELD_W-1:0]    ch3BIoCtrl,
	input  wire logic [pbm_pkg::IO_FIELD_W-1:0]    ch3AIoCtrl,
	pbm_claim_if.decoder                           claimBus
);
	// output compare mode: top bit clear and field not all zero
	function automatic logic outMode(input logic [pbm_pkg::IO_FIELD_W-1:0] f);
		outMode = !f[pbm_pkg::IO_TOP_BIT] && (f != pbm_pkg::IO_FIELD_OFF);
	endfunction : outMode

	always_comb
	begin
		claimBus.claim[pbm_pkg::PIN_B2] = ch4AOutputEnable && (combinedMode || ch4PwmSelect || outMode(ch4AIoCtrl));
		claimBus.claim[pbm_pkg::PIN_B1] = ch3BOutputEnable && (combinedMode || outMode(ch3BIoCtrl));
		claimBus.claim[pbm_pkg::PIN_B0] = ch3AOutputEnable && (combinedMode || ch3PwmSelect || outMode(ch3AIoCtrl));
		claimBus.captureEn[pbm_pkg::PIN_B2] = !combinedMode && !ch4PwmSelect && ch4AIoCtrl[pbm_pkg::IO_TOP_BIT];
		claimBus.captureEn[pbm_pkg::PIN_B1] = !combinedMode && !ch3PwmSelect && ch3BIoCtrl[pbm_pkg::IO_TOP_BIT];
		claimBus.captureEn[pbm_pkg::PIN_B0] = !combinedMode && !ch3PwmSelect && ch3AIoCtrl[pbm_pkg::IO_TOP_BIT];
	end
endmodule : pbm_claim_decode

// [pbm_claim_if.sv]
// interface: timer claim and capture-enable terms between the decoder and the top
interface pbm_claim_if;
	logic [2:0] claim;
	logic [2:0] captureEn;
	modport decoder (output claim, output captureEn);
	modport user (input claim, input captureEn);
endinterface : pbm_claim_if

// [pbm_pkg.sv]
// package: constants for the port B low pin mux
package pbm_pkg;
	localparam int PIN_COUNT = 3;
	localparam int IO_FIELD_W = 3;
	localparam int IO_TOP_BIT = 2;
	localparam logic [2:0] DIR_RESET = 3'h0;
	localparam logic [2:0] DATA_RESET = 3'h0;
	localparam logic [2:0] DIR_READ_VALUE = 3'h7;
	localparam logic [2:0] IO_FIELD_OFF = 3'h0;
	// pin indices inside the three-bit groups
	localparam int PIN_B0 = 0;
	localparam int PIN_B1 = 1;
	localparam int PIN_B2 = 2;
endpackage : pbm_pkg

// [pbm_port_b_low.sv]
// module: top of the port B low pin function select with direction and data registers
// How it works
// - channel 4 A output claims pin_b2
// - otherwise pin_b2 is input, output or pattern
// - pin_b2 input also feeds channel 4 A capture
// - channel 3 B output claims pin_b1
// - otherwise pin_b1 is input, output or pattern
// - pin_b1 input also feeds channel 3 B capture
// - channel 3 A output claims pin_b0
// - otherwise pin_b0 is input, output or pattern
// - pin_b0 input also feeds channel 3 A capture
// - data read: stored bit if output, else pin
// - direction write-only, reads ones, reset clears, standby clears
// - next-data enabled bits ignore software data writes
module pbm_port_b_low #(
	parameter int PINS = pbm_pkg::PIN_COUNT
) (
	input  wire logic                           clock,
	input  wire logic                           resetn,
	input  wire logic                           hwStandby,
	input  wire logic                           combinedMode,
	input  wire logic                           ch4PwmSelect,
	input  wire logic                           ch3PwmSelect,
	input  wire logic                           ch4AOutputEnable,
	input  wire logic                           ch3BOutputEnable,
	input  wire logic                           ch3AOutputEnable,
	input  wire logic [pbm_pkg::IO_FIELD_W-1:0] ch4AIoCtrl,
	input  wire logic [pbm_pkg::IO_FIELD_W-1:0] ch3BIoCtrl,
	input  wire logic [pbm_pkg::IO_FIELD_W-1:0] ch3AIoCtrl,
	input  wire logic [PINS-1:0]                timerOut,
	input  wire logic [PINS-1:0]                nextDataEn,
	input  wire logic [PINS-1:0]                patternLoad,
	input  wire logic [PINS-1:0]                patternData,
	input  wire logic                           dirWrite,
	input  wire logic [PINS-1:0]                dirWriteData,
	input  wire logic                           dataWrite,
	input  wire logic [PINS-1:0]                dataWriteData,
	input  wire logic [PINS-1:0]                pinIn,
	output logic      [PINS-1:0]                pinOut,
	output logic      [PINS-1:0]                pinOe,
	output logic      [PINS-1:0]                captureIn,
	output logic      [PINS-1:0]                dataReadValue,
	output logic      [PINS-1:0]                dirReadValue
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [PINS-1:0] sync1;
		logic [PINS-1:0] sync2;
		logic [PINS-1:0] dir;
		logic [PINS-1:0] data;
		logic [PINS-1:0] pinOut;
		logic [PINS-1:0] pinOe;
		logic [PINS-1:0] capture;
		logic [PINS-1:0] dataRead;
		logic [PINS-1:0] dirRead;
	} pbm_state_t;

	pbm_state_t state_q;
	pbm_state_t state_d;

	pbm_claim_if claimBus ();

	pbm_claim_decode u_decode (
		.combinedMode     (combinedMode),
		.ch4PwmSelect     (ch4PwmSelect),
		.ch3PwmSelect     (ch3PwmSelect),
		.ch4AOutputEnable (ch4AOutputEnable),
		.ch3BOutputEnable (ch3BOutputEnable),
		.ch3AOutputEnable (ch3AOutputEnable),
		.ch4AIoCtrl       (ch4AIoCtrl),
		.ch3BIoCtrl       (ch3BIoCtrl),
		.ch3AIoCtrl       (ch3AIoCtrl),
		.claimBus         (claimBus)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// registers written in this cycle steer the pins at the same edge
	logic [PINS-1:0] dirNow;
	logic [PINS-1:0] dataNow;

	always_comb
	begin
		state_d = state_q;
		state_d.sync1 = pinIn;
		// first stage is read only by the second
		state_d.sync2 = state_q.sync1;
		state_d.dir = dirWrite ? dirWriteData : state_q.dir;
		for (int i = 0; i < PINS; i++)
		begin
			if (nextDataEn[i])
			begin
				if (patternLoad[i])
					state_d.data[i] = patternData[i];
			end
			else if (dataWrite)
				state_d.data[i] = dataWriteData[i];
		end
		// standby clears both registers before they steer the pins, so only timer-claimed pins drive in that cycle
		if (hwStandby)
		begin
			state_d.dir = pbm_pkg::DIR_RESET;
			state_d.data = pbm_pkg::DATA_RESET;
		end
		dirNow = state_d.dir;
		dataNow = state_d.data;
		for (int i = 0; i < PINS; i++)
		begin
			if (claimBus.claim[i])
			begin
				state_d.pinOe[i] = 1'h1;
				state_d.pinOut[i] = timerOut[i];
			end
			else if (dirNow[i])
			begin
				// pattern bits sit in the data register, so both cases drive it
				state_d.pinOe[i] = 1'h1;
				state_d.pinOut[i] = dataNow[i];
			end
			else
			begin
				state_d.pinOe[i] = 1'h0;
				state_d.pinOut[i] = 1'h0;
			end
			state_d.capture[i] = !claimBus.claim[i] && !dirNow[i] && claimBus.captureEn[i]
				&& state_q.sync2[i];
			state_d.dataRead[i] = dirNow[i] ? dataNow[i] : state_q.sync2[i];
		end
		state_d.dirRead = pbm_pkg::DIR_READ_VALUE;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			state_q <= '0;
			state_q.dir <= pbm_pkg::DIR_RESET;
			state_q.data <= pbm_pkg::DATA_RESET;
			state_q.dirRead <= pbm_pkg::DIR_READ_VALUE;
		end
		else
			state_q <= state_d;
	end

	assign pinOut = state_q.pinOut;
	assign pinOe = state_q.pinOe;
	assign captureIn = state_q.capture;
	assign dataReadValue = state_q.dataRead;
	assign dirReadValue = state_q.dirRead;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_CLAIM_DRIVES: assert property (@(posedge clock) disable iff (!resetn)
		claimBus.claim[2] |=> pinOe[2] && pinOut[2] == $past(timerOut[2]))
		else $error("claimed pin b2 not driven by timer");
	AST_B1_CLAIM: assert property (@(posedge clock) disable iff (!resetn)
		(ch3BOutputEnable && combinedMode) |=> pinOe[1] && pinOut[1] == $past(timerOut[1]))
		else $error("pin b1 not claimed in combined mode");
	AST_B0_INPUT: assert property (@(posedge clock) disable iff (!resetn)
		(!claimBus.claim[0] && !dirNow[0]) |=> !pinOe[0])
		else $error("pin b0 driven while input");
	AST_B2_OUTPUT: assert property (@(posedge clock) disable iff (!resetn)
		(!claimBus.claim[2] && dirNow[2]) |=> pinOe[2] && pinOut[2] == $past(dataNow[2]))
		else $error("pin b2 general output wrong");
	AST_DIR_READ: assert property (@(posedge clock) disable iff (!resetn)
		dirReadValue == pbm_pkg::DIR_READ_VALUE)
		else $error("direction read not all ones");
	AST_STANDBY: assert property (@(posedge clock) disable iff (!resetn)
		hwStandby |=> state_q.dir == pbm_pkg::DIR_RESET)
		else $error("direction not cleared in standby");
	AST_NDE_BLOCK: assert property (@(posedge clock) disable iff (!resetn)
		(nextDataEn[1] && !patternLoad[1] && !hwStandby) |=> $stable(state_q.data[1]))
		else $error("data bit changed under next-data enable");
	AST_READ_PIN: assert property (@(posedge clock) disable iff (!resetn)
		!dirNow[0] |=> dataReadValue[0] == $past(state_q.sync2[0]))
		else $error("input read not pin level");
	AST_CAPTURE: assert property (@(posedge clock) disable iff (!resetn)
		(combinedMode || ch3PwmSelect) |=> !captureIn[1])
		else $error("capture routed in combined or pwm mode");

	// ------------------------------------------------------------
	// checks on claims, pin drive, capture, reads and register updates
	// ------------------------------------------------------------
	AST_B2_INPUT: assert property (@(posedge clock) disable iff (!resetn)
		(!claimBus.claim[2] && !dirNow[2]) |=> !pinOe[2] && !pinOut[2])
		else $error("pin b2 driven while input");
	AST_B1_OUTPUT: assert property (@(posedge clock) disable iff (!resetn)
		(!claimBus.claim[1] && dirNow[1]) |=> pinOe[1] && pinOut[1] == $past(dataNow[1]))
		else $error("pin b1 general output wrong");
	AST_B0_PWM_CLAIM: assert property (@(posedge clock) disable iff (!resetn)
		(ch3AOutputEnable && ch3PwmSelect) |=> pinOe[0] && pinOut[0] == $past(timerOut[0]))
		else $error("pin b0 not claimed in pwm mode");
	AST_B2_OUT_MODE: assert property (@(posedge clock) disable iff (!resetn)
		(ch4AOutputEnable && !ch4AIoCtrl[pbm_pkg::IO_TOP_BIT] && ch4AIoCtrl != pbm_pkg::IO_FIELD_OFF)
		|=> pinOe[2] && pinOut[2] == $past(timerOut[2]))
		else $error("pin b2 not claimed by output compare");
	AST_B1_NO_OE: assert property (@(posedge clock) disable iff (!resetn)
		(!ch3BOutputEnable && !dirNow[1]) |=> !pinOe[1])
		else $error("pin b1 driven without enable or direction");
	AST_CLAIM_FIRST: assert property (@(posedge clock) disable iff (!resetn)
		(claimBus.claim[1] && dirNow[1]) |=> pinOe[1] && pinOut[1] == $past(timerOut[1]))
		else $error("general output won over timer claim on pin b1");
	AST_B2_CAPTURE: assert property (@(posedge clock) disable iff (!resetn)
		(!claimBus.claim[2] && !dirNow[2] && !combinedMode && !ch4PwmSelect
		&& ch4AIoCtrl[pbm_pkg::IO_TOP_BIT]) |=> captureIn[2] == $past(state_q.sync2[2]))
		else $error("pin b2 level not routed to capture");
	AST_B1_CAPTURE_OUT: assert property (@(posedge clock) disable iff (!resetn)
		dirNow[1] |=> !captureIn[1])
		else $error("capture fed while pin b1 is output");
	AST_B0_CAPTURE: assert property (@(posedge clock) disable iff (!resetn)
		(!claimBus.claim[0] && !dirNow[0] && !combinedMode && !ch3PwmSelect
		&& ch3AIoCtrl[pbm_pkg::IO_TOP_BIT]) |=> captureIn[0] == $past(state_q.sync2[0]))
		else $error("pin b0 level not routed to capture");
	AST_B0_CAPTURE_OFF: assert property (@(posedge clock) disable iff (!resetn)
		!ch3AIoCtrl[pbm_pkg::IO_TOP_BIT] |=> !captureIn[0])
		else $error("capture fed while io field top bit clear");
	AST_READ_DATA: assert property (@(posedge clock) disable iff (!resetn)
		dirNow[2] |=> dataReadValue[2] == $past(dataNow[2]))
		else $error("output read not stored bit");
	AST_DIR_WRITE: assert property (@(posedge clock) disable iff (!resetn)
		(dirWrite && !hwStandby) |=> state_q.dir == $past(dirWriteData))
		else $error("direction write not taken");
	AST_DATA_WRITE: assert property (@(posedge clock) disable iff (!resetn)
		(dataWrite && !nextDataEn[0] && !hwStandby) |=> state_q.data[0] == $past(dataWriteData[0]))
		else $error("data write lost without next-data enable");
	AST_PATTERN_LOAD: assert property (@(posedge clock) disable iff (!resetn)
		(nextDataEn[2] && patternLoad[2] && !hwStandby) |=> state_q.data[2] == $past(patternData[2]))
		else $error("pattern transfer not loaded");
endmodule : pbm_port_b_low

// [tb_pbm_port_b_low.sv]
// file: self-checking testbench of the port B low pin function select
module tb_pbm_port_b_low;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'h0, resetn = 1'h0, hwStandby = 1'h0, combinedMode = 1'h0;
	logic ch4Pwm = 1'h0, ch3Pwm = 1'h0, oe = 1'h0, dirWrite = 1'h0, dataWrite = 1'h0;
	logic [2:0] io = 3'h0, timerOut = 3'h4, nextDataEn = 3'h0, patternLoad = 3'h0, patternData = 3'h0;
	logic [2:0] dirWriteData = 3'h0, dataWriteData = 3'h0, boardLevel = 3'h0;
	logic [2:0] pinIn, pinOut, pinOe, captureIn, dataReadValue, dirReadValue;
	int nMismatch = 0, testsRun = 0;
	always #25 clock = ~clock;
	pbm_port_b_low i_dut (.clock(clock), .resetn(resetn), .hwStandby(hwStandby), .combinedMode(combinedMode),
		.ch4PwmSelect(ch4Pwm), .ch3PwmSelect(ch3Pwm), .ch4AOutputEnable(oe), .ch3BOutputEnable(oe),
		.ch3AOutputEnable(oe), .ch4AIoCtrl(io), .ch3BIoCtrl(io), .ch3AIoCtrl(io), .timerOut(timerOut),
		.nextDataEn(nextDataEn), .patternLoad(patternLoad), .patternData(patternData), .dirWrite(dirWrite),
		.dirWriteData(dirWriteData), .dataWrite(dataWrite), .dataWriteData(dataWriteData), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .captureIn(captureIn), .dataReadValue(dataReadValue),
		.dirReadValue(dirReadValue));
	pbm_board_model i_board (.pinOut(pinOut), .pinOe(pinOe), .boardLevel(boardLevel), .pinIn(pinIn));
	task automatic chk(input string what, input logic [2:0] seen, input logic [2:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// pin levels need two sync flops plus the output flop
	task automatic settle;
		repeat (4) @(negedge clock);
	endtask : settle
	task automatic writeRegs(input logic toDir, input logic [2:0] v);
		dirWriteData = v;
		dataWriteData = v;
		dirWrite = toDir;
		dataWrite = !toDir;
		@(negedge clock);
		dirWrite = 1'h0;
		dataWrite = 1'h0;
		settle();
	endtask : writeRegs
	task automatic setTimer(input logic cm, input logic pwm, input logic en, input logic [2:0] ioCtrl);
		combinedMode = cm;
		ch4Pwm = pwm;
		ch3Pwm = pwm;
		oe = en;
		io = ioCtrl;
		settle();
	endtask : setTimer
	task automatic testDone;
		$display("checks %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : testDone
	// reset values, looked at on the falling edge of release
	task automatic scnResetValues;
		chk("pinOe", pinOe, 3'h0);
		chk("pinOut", pinOut, 3'h0);
		chk("capture", captureIn, 3'h0);
		chk("dataRead", dataReadValue, 3'h0);
		chk("dirRead", dirReadValue, 3'h7);
	endtask : scnResetValues
	task automatic scnGeneralOutput;
		writeRegs(1'h1, 3'h7);
		writeRegs(1'h0, 3'h5);
		chk("pinOe", pinOe, 3'h7);
		chk("pinOut", pinOut, 3'h5);
		chk("dataRead", dataReadValue, 3'h5);
		chk("dirRead", dirReadValue, 3'h7);
	endtask : scnGeneralOutput
	task automatic scnPattern;
		nextDataEn = 3'h7;
		writeRegs(1'h0, 3'h2);
		chk("pinOut", pinOut, 3'h5);
		patternData = 3'h3;
		patternLoad = 3'h7;
		@(negedge clock);
		patternLoad = 3'h0;
		settle();
		chk("pinOut", pinOut, 3'h3);
		chk("dataRead", dataReadValue, 3'h3);
	endtask : scnPattern
	task automatic scnTimerClaim;
		setTimer(1'h1, 1'h0, 1'h1, 3'h0);
		chk("pinOut", pinOut, 3'h4);
		chk("pinOe", pinOe, 3'h7);
		setTimer(1'h0, 1'h1, 1'h1, 3'h0);
		chk("pinOut", pinOut, 3'h6);
		setTimer(1'h0, 1'h0, 1'h1, 3'h3);
		chk("pinOut", pinOut, 3'h4);
		setTimer(1'h0, 1'h0, 1'h1, 3'h4);
		chk("pinOut", pinOut, 3'h3);
		setTimer(1'h0, 1'h0, 1'h0, 3'h3);
		chk("pinOut", pinOut, 3'h3);
	endtask : scnTimerClaim
	task automatic scnCapture;
		nextDataEn = 3'h0;
		boardLevel = 3'h5;
		setTimer(1'h0, 1'h0, 1'h0, 3'h4);
		writeRegs(1'h1, 3'h0);
		chk("capture", captureIn, 3'h5);
		boardLevel = 3'h2;
		settle();
		chk("capture", captureIn, 3'h2);
		chk("dataRead", dataReadValue, 3'h2);
		chk("pinOe", pinOe, 3'h0);
	endtask : scnCapture
	// pwm, combined mode and a cleared top bit each keep the pin level off the capture inputs
	task automatic scnCaptureBlocked;
		setTimer(1'h0, 1'h1, 1'h0, 3'h4);
		chk("capture", captureIn, 3'h0);
		chk("pinOe", pinOe, 3'h0);
		setTimer(1'h1, 1'h0, 1'h0, 3'h4);
		chk("capture", captureIn, 3'h0);
		chk("pinOe", pinOe, 3'h0);
		setTimer(1'h0, 1'h0, 1'h1, 3'h0);
		chk("capture", captureIn, 3'h0);
		chk("pinOe", pinOe, 3'h0);
		chk("dataRead", dataReadValue, 3'h2);
		setTimer(1'h0, 1'h0, 1'h0, 3'h4);
		chk("capture", captureIn, 3'h2);
	endtask : scnCaptureBlocked
	task automatic scnStandby;
		writeRegs(1'h1, 3'h7);
		chk("pinOut", pinOut, 3'h3);
		hwStandby = 1'h1;
		@(negedge clock);
		hwStandby = 1'h0;
		settle();
		chk("pinOe", pinOe, 3'h0);
		writeRegs(1'h1, 3'h7);
		chk("pinOut", pinOut, 3'h0);
		chk("pinOe", pinOe, 3'h7);
	endtask : scnStandby
	task automatic scnMidReset;
		writeRegs(1'h0, 3'h5);
		chk("pinOut", pinOut, 3'h5);
		resetn = 1'h0;
		repeat (2) @(negedge clock);
		chk("pinOe", pinOe, 3'h0);
		chk("pinOut", pinOut, 3'h0);
		chk("dirRead", dirReadValue, 3'h7);
		resetn = 1'h1;
		settle();
		chk("pinOe", pinOe, 3'h0);
		chk("dataRead", dataReadValue, 3'h2);
		writeRegs(1'h1, 3'h7);
		chk("pinOut", pinOut, 3'h0);
	endtask : scnMidReset
	initial
	begin
		repeat (8) @(negedge clock);
		resetn = 1'h1;
		scnResetValues();
		scnGeneralOutput();
		scnPattern();
		scnTimerClaim();
		scnCapture();
		scnCaptureBlocked();
		scnStandby();
		scnMidReset();
		testDone();
	end
endmodule : tb_pbm_port_b_low
